/* File: mmbc_params.svh */
// Constants for the minimum-mode bus control block
`ifndef MMBC_PARAMS_SVH
`define MMBC_PARAMS_SVH

// Clock periods per bus T-state: one high phase, one low phase
`define MMBC_CLK_PERIOD_NS      5
`define MMBC_PHASES_PER_TSTATE  2

// Level shown by a floated control line (external pull-up)
`define MMBC_FLOAT_LEVEL        1'b1

// Reset values of the strobes and select lines
`define MMBC_RST_STROBE_N       1'b1
`define MMBC_RST_ALE            1'b0
`define MMBC_RST_CTL_OUT        4'hf
`define MMBC_RST_CTL_OE         4'h0

// Synchroniser depth for pin inputs
`define MMBC_SYNC_STAGES        2

`endif

/* File: mmbc_pkg.sv */
// Types shared by the minimum-mode bus control block
package mmbc_pkg;

  // Bus T-states, plus the state in which another master owns the bus
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_T1,
    ST_T2,
    ST_T3,
    ST_TW,
    ST_T4,
    ST_HOLD
  } mmbc_state_t;

  // One bus cycle request from the core
  typedef struct packed {
    logic is_mem;    // 1 memory, 0 I/O
    logic is_write;  // 1 write, 0 read
    logic is_int_ack_strobe_n;   // Interrupt acknowledge cycle
  } mmbc_cmd_t;

  // The four floatable control lines
  typedef struct packed {
    logic mio;            // Memory/IO select
    logic wr_n;           // Write strobe
    logic xcvr_direction; // Transceiver direction
    logic xcvr_enable_n;  // Transceiver enable
  } mmbc_ctl_t;

endpackage

/* File: mmbc_sync.sv */
// Two-flop synchroniser for pin inputs
`timescale 1ns/10ps
`include "mmbc_params.svh"

module mmbc_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         mclk,
  input  wire logic         sys_rst,
  // Data
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  logic [W-1:0] meta_reg;

  // First stage feeds only the second stage
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      meta_reg <= '0;
      dout     <= '0;
    end
    else
    begin
      meta_reg <= din;
      dout     <= meta_reg;
    end
  end

endmodule

/* File: mmbc_top.sv */
// Minimum-mode local bus control: strobes, transceiver control and hold handshake
//
// What this block does
// - Minimum-mode behaviour only while the mode strap input is high; hold and grant work at either strap level.
// - Memory/IO select valid from preceding t4 to final t4; high memory.
// - Select, write, direction, enable float as logic one during bus grant.
// - Write strobe low in t2, t3 and wait states of write cycles.
// - Interrupt acknowledge strobe low in t2, t3, wait states of acknowledge.
// - Interrupt acknowledge strobe is always driven, never floated.
// - Address latch pulse high during clock low phase of t1.
// - Address latch pulse is always driven, never floated.
// - Direction timed like memory/IO select; high transmit, low receive.
// - Transceiver enable low during every bus cycle kind.
// - Read and acknowledge: enable from middle of t2 to middle of t4.
// - Write: enable from start of t2 to middle of t4.
// - Hold request answered by raising grant in middle of t4 or idle.
// - Bus and control lines float at the moment grant rises.
// - Hold low drops grant; lines driven again only at next cycle.
`timescale 1ns/10ps
`include "mmbc_params.svh"

module mmbc_top (
  // Clock and reset
  input  wire logic               mclk,
  input  wire logic               sys_rst,
  // Pins in
  input  wire logic               mode_strap,
  input  wire logic               hold_req,
  // Core request side
  input  wire logic               req_valid,
  input  wire mmbc_pkg::mmbc_cmd_t req_cmd,
  input  wire logic               wait_req,
  output logic                    req_ready,
  // Control pins
  output mmbc_pkg::mmbc_ctl_t     ctl_out,
  output mmbc_pkg::mmbc_ctl_t     ctl_oe,
  output logic                    int_ack_strobe_n,
  output logic                    ale,
  output logic                    bus_grant,
  output logic                    ad_drive
);

  logic                  min_mode;
  logic                  hold_s;
  mmbc_pkg::mmbc_state_t state_reg, state_next;
  logic                  phase_reg, phase_next;
  mmbc_pkg::mmbc_cmd_t   cmd_reg, cmd_next;
  logic                  pend_reg, pend_next;
  logic                  grant_next;
  logic                  drive_reg, drive_next;
  logic                  accept;
  logic                  grant_now;
  logic                  strobe_st;
  logic                  den_act;

  // Pins cross into the clock domain; the hold setup is not guaranteed
  // Two pins share one synchroniser, so the width is the pin count, not the depth
  mmbc_sync #(.W(2)) u_sync (
    .mclk    (mclk),
    .sys_rst (sys_rst),
    .din     ({mode_strap, hold_req}),
    .dout    ({min_mode, hold_s})
  );

  // Decisions at the first half of a t4 or idle state
  always_comb
  begin
    grant_now  = 1'b0;
    accept     = 1'b0;
    if ((state_reg == mmbc_pkg::ST_T4 || state_reg == mmbc_pkg::ST_IDLE) && !phase_reg && !bus_grant)
    begin
      if (hold_s)
        grant_now = 1'b1;
      else if (min_mode && req_valid && !pend_reg)
        accept = 1'b1;
    end
  end

  // Next state; a T-state is two clocks, so moves happen on the low phase only
  always_comb
  begin
    state_next = state_reg;
    phase_next = ~phase_reg;
    cmd_next   = accept ? req_cmd : cmd_reg;
    pend_next  = pend_reg | accept;
    grant_next = bus_grant | grant_now;
    drive_next = accept ? 1'b1 : (grant_now ? 1'b0 : drive_reg);
    if (phase_reg)
    begin
      case (state_reg)
        mmbc_pkg::ST_IDLE,
        mmbc_pkg::ST_T4:
        begin
          if (bus_grant)
            state_next = mmbc_pkg::ST_HOLD;
          else if (pend_reg)
          begin
            state_next = mmbc_pkg::ST_T1;
            pend_next  = 1'b0;
          end
          else
            state_next = mmbc_pkg::ST_IDLE;
        end
        mmbc_pkg::ST_T1: state_next = mmbc_pkg::ST_T2;
        mmbc_pkg::ST_T2: state_next = mmbc_pkg::ST_T3;
        mmbc_pkg::ST_T3: state_next = wait_req ? mmbc_pkg::ST_TW : mmbc_pkg::ST_T4;
        mmbc_pkg::ST_TW: state_next = wait_req ? mmbc_pkg::ST_TW : mmbc_pkg::ST_T4;
        mmbc_pkg::ST_HOLD:
        begin
          if (!hold_s)
          begin
            state_next = mmbc_pkg::ST_IDLE;
            grant_next = 1'b0;
          end
        end
        default: state_next = mmbc_pkg::ST_IDLE;
      endcase
    end
  end

  // Sequencer state
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_reg <= mmbc_pkg::ST_IDLE;
      phase_reg <= 1'b0;
      cmd_reg   <= '0;
      pend_reg  <= 1'b0;
      drive_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      phase_reg <= phase_next;
      cmd_reg   <= cmd_next;
      pend_reg  <= pend_next;
      drive_reg <= drive_next;
    end
  end

  // Output terms from the next state, so registered pins line up with the state
  always_comb
  begin
    strobe_st = (state_next == mmbc_pkg::ST_T2) || (state_next == mmbc_pkg::ST_T3) ||
                (state_next == mmbc_pkg::ST_TW);
    den_act   = ((state_next == mmbc_pkg::ST_T2) && (phase_next || cmd_next.is_write)) ||
                (state_next == mmbc_pkg::ST_T3) || (state_next == mmbc_pkg::ST_TW) ||
                ((state_next == mmbc_pkg::ST_T4) && !phase_next);
  end

  // Floatable control lines; floated lines show the pull-up level
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      ctl_out <= `MMBC_RST_CTL_OUT;
      ctl_oe  <= `MMBC_RST_CTL_OE;
    end
    else if (drive_next && min_mode && !grant_next)
    begin
      ctl_out.mio            <= cmd_next.is_mem;
      ctl_out.wr_n           <= ~(cmd_next.is_write && strobe_st);
      ctl_out.xcvr_direction <= cmd_next.is_write;
      ctl_out.xcvr_enable_n  <= ~den_act;
      ctl_oe                 <= 4'hf;
    end
    else
    begin
      ctl_out <= {4{`MMBC_FLOAT_LEVEL}};
      ctl_oe  <= 4'h0;
    end
  end

  // Always-driven strobes: no enable exists for them
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      int_ack_strobe_n <= `MMBC_RST_STROBE_N;
      ale              <= `MMBC_RST_ALE;
    end
    else
    begin
      int_ack_strobe_n <= ~(min_mode && cmd_next.is_int_ack_strobe_n && strobe_st);
      ale              <= min_mode && (state_next == mmbc_pkg::ST_T1) && phase_next;
    end
  end

  // Handshake outputs
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      bus_grant <= 1'b0;
      ad_drive  <= 1'b0;
      req_ready <= 1'b0;
    end
    else
    begin
      bus_grant <= grant_next;
      ad_drive  <= drive_next && !grant_next && min_mode;
      req_ready <= accept;
    end
  end

  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  AST_ALE_IN_T1_LOW: assert property (ale |-> state_reg == mmbc_pkg::ST_T1 && phase_reg)
    else $error("Address latch pulse outside t1 low phase");
  AST_ALE_ONE_CYCLE: assert property ($rose(ale) |=> !ale)
    else $error("Address latch pulse longer than one clock");
  AST_WR_STROBE: assert property (!ctl_out.wr_n |-> cmd_reg.is_write && ctl_oe.wr_n &&
    (state_reg == mmbc_pkg::ST_T2 || state_reg == mmbc_pkg::ST_T3 || state_reg == mmbc_pkg::ST_TW))
    else $error("Write strobe low outside write t2/t3/wait");
  AST_INT_ACK_STROBE_N_STROBE: assert property (!int_ack_strobe_n |-> cmd_reg.is_int_ack_strobe_n &&
    (state_reg == mmbc_pkg::ST_T2 || state_reg == mmbc_pkg::ST_T3 || state_reg == mmbc_pkg::ST_TW))
    else $error("Acknowledge strobe low outside t2/t3/wait");
  AST_GRANT_FLOATS: assert property (bus_grant |-> ctl_oe == 4'h0 && ctl_out == 4'hf && !ad_drive)
    else $error("Lines driven during bus grant");
  AST_DEN_READ_MID: assert property (state_reg == mmbc_pkg::ST_T2 && !phase_reg && !cmd_reg.is_write
    |-> ctl_out.xcvr_enable_n)
    else $error("Read enable asserted before middle of t2");
  AST_DEN_WRITE_START: assert property (state_reg == mmbc_pkg::ST_T2 && !phase_reg && cmd_reg.is_write
    && ctl_oe.xcvr_enable_n |-> !ctl_out.xcvr_enable_n)
    else $error("Write enable missing at start of t2");
  AST_DEN_T4_END: assert property (state_reg == mmbc_pkg::ST_T4 && phase_reg |-> ctl_out.xcvr_enable_n)
    else $error("Enable held past middle of t4");
  AST_GRANT_MID: assert property ($rose(bus_grant) |-> !$past(phase_reg) &&
    ($past(state_reg) == mmbc_pkg::ST_T4 || $past(state_reg) == mmbc_pkg::ST_IDLE))
    else $error("Grant raised outside middle of t4 or idle");
  AST_GRANT_DROP: assert property (state_reg == mmbc_pkg::ST_HOLD && phase_reg && !hold_s
    |=> !bus_grant && !ad_drive)
    else $error("Grant not dropped after hold went low");
  AST_CYCLE_ORDER: assert property (state_reg == mmbc_pkg::ST_T1 && phase_reg |=>
    state_reg == mmbc_pkg::ST_T2 [*2] ##1 state_reg == mmbc_pkg::ST_T3)
    else $error("Bus cycle state order broken");
  AST_MIO_STABLE: assert property (state_reg inside {mmbc_pkg::ST_T2, mmbc_pkg::ST_T3, mmbc_pkg::ST_TW}
    |-> $stable(ctl_out.mio) && $stable(ctl_out.xcvr_direction))
    else $error("Select or direction changed inside a cycle");
  AST_MODE_GATE: assert property (!min_mode |=> ctl_oe == 4'h0 && !ale)
    else $error("Control lines active outside minimum mode");

  COV_WRITE: cover property (!ctl_out.wr_n ##1 ctl_out.wr_n);
  COV_INT_ACK_STROBE_N: cover property (!int_ack_strobe_n);
  COV_WAIT: cover property (state_reg == mmbc_pkg::ST_TW);
  COV_HOLD: cover property ($rose(bus_grant) ##[1:40] $fell(bus_grant));

endmodule

/* File: mmbc_far_model.sv */
// Far side: competing master, address latch and pulled-up control lines
`timescale 1ns/10ps

module mmbc_far_model (
  // Clock and reset
  input  wire logic                mclk,
  input  wire logic                sys_rst,
  // Bench control
  input  wire logic                want_bus,
  // Device pins
  input  wire logic                ale,
  input  wire mmbc_pkg::mmbc_ctl_t ctl_out,
  input  wire mmbc_pkg::mmbc_ctl_t ctl_oe,
  output logic                     hold_req,
  output mmbc_pkg::mmbc_ctl_t      ctl_pin,
  output logic [7:0]               latch_count
);
  // Hold launched from the clock, so setup is always met
  always_ff @(posedge mclk or posedge sys_rst)
    if (sys_rst)
      hold_req <= 1'b0;
    else
      hold_req <= want_bus;

  // Pull-ups: a floated line reads as one
  assign ctl_pin = ctl_out | ~ctl_oe;

  // Address latch: one capture per latch pulse
  always_ff @(posedge mclk or posedge sys_rst)
    if (sys_rst)
      latch_count <= 8'h00;
    else
      latch_count <= latch_count + {7'h00, ale};
endmodule

/* File: tb_mmbc_top.sv */
// Self-checking testbench for the minimum-mode bus control block
`timescale 1ns/10ps

module tb_mmbc_top;
  logic                mclk       = 1'b0;
  logic                sys_rst    = 1'b1;
  logic                mode_strap = 1'b1;
  logic                want_bus   = 1'b0;
  logic                req_valid  = 1'b0;
  mmbc_pkg::mmbc_cmd_t req_cmd    = '0;
  logic                wait_req   = 1'b0;
  logic                hold_req;
  logic                req_ready;
  logic                int_ack_strobe_n;
  logic                ale;
  logic                bus_grant;
  logic                ad_drive;
  mmbc_pkg::mmbc_ctl_t ctl_out;
  mmbc_pkg::mmbc_ctl_t ctl_oe;
  mmbc_pkg::mmbc_ctl_t ctl_pin;
  logic [7:0]          latch_count;
  int                  fails      = 0;
  int                  n_compared = 0;

  // 200 MHz clock
  always #2.5 mclk = ~mclk;

  mmbc_top u_mmbc_top (.mclk(mclk), .sys_rst(sys_rst), .mode_strap(mode_strap), .hold_req(hold_req),
    .req_valid(req_valid), .req_cmd(req_cmd), .wait_req(wait_req), .req_ready(req_ready),
    .ctl_out(ctl_out), .ctl_oe(ctl_oe), .int_ack_strobe_n(int_ack_strobe_n), .ale(ale),
    .bus_grant(bus_grant), .ad_drive(ad_drive));

  mmbc_far_model u_mmbc_far_model (.mclk(mclk), .sys_rst(sys_rst), .want_bus(want_bus), .ale(ale),
    .ctl_out(ctl_out), .ctl_oe(ctl_oe), .hold_req(hold_req), .ctl_pin(ctl_pin), .latch_count(latch_count));

  // Step to just after the next rising edge
  task automatic tick();
    @(posedge mclk);
    #1;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One bus cycle; k counts clocks from the accepting edge
  task automatic run_cycle(input mmbc_pkg::mmbc_cmd_t cmd, input int w, input logic grab);
    int         k;
    int         last;
    logic [7:0] n0;
    req_valid = 1'b1;
    req_cmd   = cmd;
    k         = 0;
    while (req_ready !== 1'b1 && k < 40)
    begin
      tick();
      k++;
    end
    chk(req_ready, 8'h01);
    req_valid = 1'b0;
    n0        = latch_count;
    // A grant in the last half-state floats the lines, so stop early then
    last      = 9 + 2 * w - grab;
    for (k = 2; k <= last; k++)
    begin
      tick();
      if (grab && k == 2)
        want_bus = 1'b1;
      wait_req = (k >= 6 && k < 6 + 2 * w);
      chk(ctl_oe, 8'h0f);
      chk(ad_drive, 8'h01);
      chk(bus_grant, 8'h00);
      chk(ctl_pin.mio, cmd.is_mem);
      chk(ctl_pin.xcvr_direction, cmd.is_write);
      chk(ale, 8'(k == 3));
      chk(ctl_pin.wr_n, !(cmd.is_write && k >= 4 && k <= 7 + 2 * w));
      chk(int_ack_strobe_n, !(cmd.is_int_ack_strobe_n && k >= 4 && k <= 7 + 2 * w));
      chk(ctl_pin.xcvr_enable_n, !(k >= (cmd.is_write ? 4 : 5) && k <= 8 + 2 * w));
    end
    chk(latch_count, n0 + 8'h01);
    $display("test cycle %b waits %0d done", cmd, w);
  endtask

  // Grant requested mid-cycle, served in the middle of its t4, then released
  task automatic test_hold();
    int k;
    run_cycle(3'b110, 0, 1'b1);
    k = 0;
    while (bus_grant !== 1'b1 && k < 20)
    begin
      tick();
      k++;
    end
    chk(bus_grant, 8'h01);
    chk(ctl_oe, 8'h00);
    chk(ctl_pin, 8'h0f);
    chk(ad_drive, 8'h00);
    req_valid = 1'b1;
    for (k = 0; k < 8; k++)
    begin
      tick();
      chk(req_ready, 8'h00);
      chk(int_ack_strobe_n, 8'h01);
      chk(ale, 8'h00);
    end
    req_valid = 1'b0;
    want_bus  = 1'b0;
    for (k = 0; k < 10; k++)
      tick();
    chk(bus_grant, 8'h00);
    chk(ctl_oe, 8'h00);
    chk(ad_drive, 8'h00);
    run_cycle(3'b100, 0, 1'b0);
    $display("test hold done");
  endtask

  // Strap low: nothing accepted, lines floated
  task automatic test_strap();
    int k;
    mode_strap = 1'b0;
    repeat (4) tick();
    req_valid = 1'b1;
    for (k = 0; k < 12; k++)
    begin
      tick();
      chk(req_ready, 8'h00);
      chk(ctl_oe, 8'h00);
    end
    mode_strap = 1'b1;
    run_cycle(3'b010, 0, 1'b0);
    $display("test strap done");
  endtask

  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    repeat (16) tick();
    sys_rst = 1'b0;
    repeat (3) tick();
    chk(ctl_oe, 8'h00);
    chk(bus_grant, 8'h00);
    chk(ad_drive, 8'h00);
    run_cycle(3'b100, 0, 1'b0);
    run_cycle(3'b110, 2, 1'b0);
    run_cycle(3'b000, 0, 1'b0);
    run_cycle(3'b010, 1, 1'b0);
    run_cycle(3'b001, 1, 1'b0);
    test_hold();
    test_strap();
    results();
  end

  // Watchdog, far beyond the fewer than two hundred cycles the tests need
  initial
  begin
    #25000;
    fails++;
    results();
  end
endmodule
